// ==== rtl/dpe_core.sv ====
// Debug entry, fetch address tracking and exception priority for the core.
// Assumes event inputs are one-cycle pulses on SYS_CLK from core logic,
// except EXTERNAL_HALT_REQUEST which is a pin and is synchronised here.
`timescale 1ns/100ps
`default_nettype none
module dpe_core
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Entry events from the core pipeline, plus the external halt pin.
  input wire logic BREAKPOINT_HIT,
  input wire logic PREFETCH_ABORT,
  input wire logic WATCHPOINT_HIT,
  input wire logic DATA_ABORT,
  input wire logic IRQ_PENDING,
  input wire logic FIQ_PENDING,
  input wire logic ABORT_VECTOR_FETCHED,
  input wire logic EXTERNAL_HALT_REQUEST,
  // Debug instruction execution.
  input wire logic DEBUG_INSN_EXEC,
  input wire logic SYSTEM_SPEED_FLAG,
  input wire logic SYS_ACCESS_DONE,
  input wire logic SYS_ACCESS_ABORT,
  input wire logic RESTART,
  input wire logic [31:0] RESTART_PC,
  input wire logic [4:0] RUN_MODE,
  // State seen by the debugger.
  output logic [31:0] FETCH_PC,
  output logic [4:0] CURRENT_STATUS_WORD,
  output logic [4:0] SAVED_STATUS_WORD,
  output logic IN_DEBUG,
  output logic IRQ_DISABLE,
  output logic IRQ_REMEMBERED,
  output logic ABORT_REMEMBERED,
  output logic TAKE_PREFETCH_ABORT,
  output var dpe_pkg::dpe_cause_t ENTRY_CAUSE
);
  import dpe_pkg::*;

  dpe_state_t state, next_state;
  logic [31:0] pc, next_pc, add_words, add_sum;
  logic [4:0] mode, next_mode, smode, next_smode;
  logic irq_mem, next_irq_mem, abt_mem, next_abt_mem;
  logic pfa, next_pfa, speed_armed, next_speed_armed;
  dpe_cause_t cause, next_cause;
  logic halt_meta, halt_sync;
  logic [31:0] add_base;

  // Two-stage synchroniser for the external halt pin.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
    end
    else
    begin
      halt_meta <= EXTERNAL_HALT_REQUEST;
      halt_sync <= halt_meta;
    end
  end

  // Shared modular adder for every fetch address increment.
  dpe_pc_adder u_add
  (
    .pc(add_base),
    .words(add_words),
    .sum(add_sum)
  );

  // Next-state, address and mode computation.
  always_comb
  begin
    next_state = state;
    next_pc = pc;
    next_mode = mode;
    next_smode = smode;
    next_irq_mem = irq_mem;
    next_abt_mem = abt_mem;
    next_pfa = 1'b0;
    next_cause = cause;
    next_speed_armed = speed_armed;
    add_base = pc;
    add_words = 32'h0000_0000;
    case (state)
      ST_RUN:
      begin
        next_mode = RUN_MODE;
        if (WATCHPOINT_HIT && DATA_ABORT)
        begin
          // Entry waits for abort mode and the vector fetch.
          next_state = ST_EXC_WAIT;
          next_smode = RUN_MODE;
          next_mode = MODE_ABORT;
          next_abt_mem = 1'b1;
        end
        else if (WATCHPOINT_HIT && (IRQ_PENDING || FIQ_PENDING))
        begin
          // Interrupt changes mode only for watchpointed accesses.
          next_state = ST_EXC_WAIT;
          next_smode = RUN_MODE;
          next_mode = FIQ_PENDING ? MODE_FIQ : MODE_IRQ;
          next_irq_mem = 1'b1;
        end
        else if (WATCHPOINT_HIT)
        begin
          add_words = INC_WATCHPOINT;
          next_pc = add_sum;
          next_state = ST_DEBUG;
          next_cause = CAUSE_WATCH;
        end
        else if (BREAKPOINT_HIT && PREFETCH_ABORT)
        begin
          next_pfa = 1'b1;
        end
        else if (BREAKPOINT_HIT)
        begin
          // Pending interrupts are ignored on breakpoints.
          add_words = INC_BREAKPOINT;
          next_pc = add_sum;
          next_state = ST_DEBUG;
          next_cause = CAUSE_BREAK;
        end
        else if (halt_sync)
        begin
          add_words = INC_HALT_REQ;
          next_pc = add_sum;
          next_state = ST_DEBUG;
          next_cause = CAUSE_HALT_REQ;
        end
      end
      ST_EXC_WAIT:
      begin
        if (ABORT_VECTOR_FETCHED)
        begin
          add_words = INC_WATCH_EXC;
          next_pc = add_sum;
          next_state = ST_DEBUG;
          next_cause = CAUSE_WATCH_EXC;
        end
      end
      ST_DEBUG:
      begin
        if (RESTART)
        begin
          next_pc = RESTART_PC;
          next_state = ST_RUN;
          next_cause = CAUSE_NONE;
          next_speed_armed = 1'b0;
        end
        else if (DEBUG_INSN_EXEC && speed_armed)
        begin
          // Flag set on the previous debug instruction runs this one at system speed.
          next_state = ST_SYS_ACCESS;
          next_speed_armed = 1'b0;
        end
        else if (DEBUG_INSN_EXEC)
        begin
          add_words = INC_DEBUG_INSN;
          next_pc = add_sum;
          next_speed_armed = SYSTEM_SPEED_FLAG;
        end
      end
      ST_SYS_ACCESS:
      begin
        if (SYS_ACCESS_ABORT)
        begin
          next_smode = mode;
          next_mode = MODE_ABORT;
          next_abt_mem = 1'b1;
          next_state = ST_SYS_ABORT;
        end
        else if (SYS_ACCESS_DONE)
        begin
          add_words = INC_SYS_SPEED;
          next_pc = add_sum;
          next_state = ST_DEBUG;
        end
      end
      ST_SYS_ABORT:
      begin
        // Back to debug in abort mode; address no longer names the fault.
        add_words = INC_SYS_SPEED;
        next_pc = add_sum;
        next_state = ST_DEBUG;
        next_cause = CAUSE_SYS_ABORT;
      end
      default:
      begin
        next_state = ST_RUN;
      end
    endcase
  end

  // Registers the state, address and mode.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      state <= ST_RUN;
      pc <= PC_RESET;
      mode <= MODE_SVC;
      smode <= MODE_SVC;
      irq_mem <= 1'b0;
      abt_mem <= 1'b0;
      pfa <= 1'b0;
      cause <= CAUSE_NONE;
      speed_armed <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pc <= next_pc;
      mode <= next_mode;
      smode <= next_smode;
      irq_mem <= next_irq_mem;
      abt_mem <= next_abt_mem;
      pfa <= next_pfa;
      cause <= next_cause;
      speed_armed <= next_speed_armed;
    end
  end

  // Output drive; interrupts held off in debug and while waiting.
  assign FETCH_PC = pc;
  assign CURRENT_STATUS_WORD = mode;
  assign SAVED_STATUS_WORD = smode;
  assign IN_DEBUG = (state == ST_DEBUG);
  assign IRQ_DISABLE = (state != ST_RUN);
  assign IRQ_REMEMBERED = irq_mem;
  assign ABORT_REMEMBERED = abt_mem;
  assign TAKE_PREFETCH_ABORT = pfa;
  assign ENTRY_CAUSE = cause;

  // Assertions.
  property p_bkpt_inc;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == ST_RUN && BREAKPOINT_HIT && !PREFETCH_ABORT && !WATCHPOINT_HIT
     && !halt_sync) |=> (pc == $past(pc) + 32'h0000_0010);
  endproperty
  a_bkpt_inc: assert property (p_bkpt_inc)
    else $error("Breakpoint entry did not add 16 bytes.");

  property p_dbg_insn;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == ST_DEBUG && DEBUG_INSN_EXEC && !speed_armed && !RESTART)
    |=> (pc == $past(pc) + 32'h0000_0004) && IN_DEBUG;
  endproperty
  a_dbg_insn: assert property (p_dbg_insn)
    else $error("Debug instruction did not add 4 bytes.");

  property p_watch_inc;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == ST_RUN && WATCHPOINT_HIT && !DATA_ABORT && !IRQ_PENDING
     && !FIQ_PENDING) |=> (pc == $past(pc) + 32'h0000_0010) && IN_DEBUG;
  endproperty
  a_watch_inc: assert property (p_watch_inc)
    else $error("Watchpoint entry did not add 16 bytes.");

  property p_watch_abort;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == ST_RUN && WATCHPOINT_HIT && DATA_ABORT)
    |=> !IN_DEBUG && CURRENT_STATUS_WORD == MODE_ABORT && ABORT_REMEMBERED;
  endproperty
  a_watch_abort: assert property (p_watch_abort)
    else $error("Watchpoint with abort entered debug too early.");

  property p_watch_irq;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == ST_RUN && WATCHPOINT_HIT && !DATA_ABORT && IRQ_PENDING
     && !FIQ_PENDING) |=> CURRENT_STATUS_WORD == MODE_IRQ && IRQ_REMEMBERED;
  endproperty
  a_watch_irq: assert property (p_watch_irq)
    else $error("Interrupt on watchpoint lost its mode.");

  property p_exc_inc;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == ST_EXC_WAIT && ABORT_VECTOR_FETCHED)
    |=> (pc == $past(pc) + 32'h0000_000C) && IN_DEBUG;
  endproperty
  a_exc_inc: assert property (p_exc_inc)
    else $error("Watchpoint with exception did not add 12 bytes.");

  property p_sys_inc;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == ST_SYS_ACCESS && SYS_ACCESS_DONE && !SYS_ACCESS_ABORT)
    |=> (pc == $past(pc) + 32'h0000_000C) && IN_DEBUG;
  endproperty
  a_sys_inc: assert property (p_sys_inc)
    else $error("System-speed access did not add 12 bytes.");

  property p_sys_abort;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == ST_SYS_ACCESS && SYS_ACCESS_ABORT)
    |=> CURRENT_STATUS_WORD == MODE_ABORT && !IN_DEBUG ##1 IN_DEBUG;
  endproperty
  a_sys_abort: assert property (p_sys_abort)
    else $error("Aborted system access did not pass through abort mode.");

  property p_pfa;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == ST_RUN && BREAKPOINT_HIT && PREFETCH_ABORT && !WATCHPOINT_HIT)
    |=> TAKE_PREFETCH_ABORT && !IN_DEBUG && $stable(pc);
  endproperty
  a_pfa: assert property (p_pfa)
    else $error("Breakpoint was not dropped for prefetch abort.");

  // A pending interrupt must never move the mode while halted.
  property p_irq_off;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    IN_DEBUG |-> IRQ_DISABLE ##1 $stable(CURRENT_STATUS_WORD);
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("Interrupts enabled in debug state.");

  property p_halt;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (state == ST_RUN && halt_sync && !WATCHPOINT_HIT && !BREAKPOINT_HIT)
    |=> (pc == $past(pc) + 32'h0000_000C);
  endproperty
  a_halt: assert property (p_halt)
    else $error("Halt request entry did not add 12 bytes.");

  c_bkpt: cover property (@(posedge SYS_CLK) cause == CAUSE_BREAK);
  c_wexc: cover property (@(posedge SYS_CLK) cause == CAUSE_WATCH_EXC);
  c_halt: cover property (@(posedge SYS_CLK) cause == CAUSE_HALT_REQ);
  c_sys: cover property (@(posedge SYS_CLK) state == ST_SYS_ACCESS);
endmodule
`default_nettype wire

// ==== rtl/dpe_pkg.sv ====
// Package for the debug entry program counter and priority block.
// Assumes a 32-bit word-addressed fetch counter held in byte units.
package dpe_pkg;
  // Word size in bytes and address width.
  localparam int PC_WIDTH = 32;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  // Word increments applied per event.
  localparam logic [31:0] INC_BREAKPOINT = 32'h0000_0004;
  localparam logic [31:0] INC_WATCHPOINT = 32'h0000_0004;
  localparam logic [31:0] INC_WATCH_EXC = 32'h0000_0003;
  localparam logic [31:0] INC_HALT_REQ = 32'h0000_0003;
  localparam logic [31:0] INC_DEBUG_INSN = 32'h0000_0001;
  localparam logic [31:0] INC_SYS_SPEED = 32'h0000_0003;
  // Reset value of the fetch address.
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  // Processor mode codes, five bits.
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABORT = 5'h17;
  // Entry cause codes reported to the debugger side.
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'b000,
    CAUSE_BREAK = 3'b001,
    CAUSE_WATCH = 3'b010,
    CAUSE_WATCH_EXC = 3'b011,
    CAUSE_HALT_REQ = 3'b100,
    CAUSE_SYS_ABORT = 3'b101
  } dpe_cause_t;
  // Core state machine.
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_EXC_WAIT = 3'b001,
    ST_DEBUG = 3'b010,
    ST_SYS_ACCESS = 3'b011,
    ST_SYS_ABORT = 3'b100
  } dpe_state_t;
endpackage

// ==== rtl/dpe_pc_adder.sv ====
// Word-aligned modular adder for the fetch address.
// Assumes the increment is given in words; the result wraps at 32 bits.
`timescale 1ns/100ps
`default_nettype none
module dpe_pc_adder
(
  // Operands.
  input wire logic [31:0] pc,
  input wire logic [31:0] words,
  // Result.
  output logic [31:0] sum
);
  import dpe_pkg::*;

  // Adds the word count scaled to bytes and forces word alignment.
  always_comb
  begin
    sum = (pc + (words << 2)) & ~(WORD_BYTES - 32'h0000_0001);
  end
endmodule
`default_nettype wire

// ==== tb/dpe_dbg_model.sv ====
// Behavioural model of the external debugger that scans instructions in.
// Assumes the core takes its pulses on the rising edge of clk.
`timescale 1ns/100ps
`default_nettype none
module dpe_dbg_model
(
  // Clock and the fetch address read back from the core.
  input wire logic clk,
  input wire logic [31:0] pc,
  // Debug instruction and exit controls.
  output logic insn,
  output logic flag,
  output logic acc_done,
  output logic acc_abort,
  output logic restart,
  output logic [31:0] target
);
  int n_cnt;
  int s_cnt;

  // Idle values at time zero.
  initial
  begin
    insn = 1'b0;
    flag = 1'b0;
    acc_done = 1'b0;
    acc_abort = 1'b0;
    restart = 1'b0;
    target = 32'h5A5A_5A5A;
  end

  // One scanned instruction; the speed flag is driven on the same edge as the word.
  task automatic exec(input logic f);
    @(posedge clk);
    insn <= 1'b1;
    flag <= f;
    @(posedge clk);
    insn <= 1'b0;
    flag <= ~f;
  endtask

  // Three instructions, the middle one at system speed when asked.
  task automatic run(input logic sys, input logic ab);
    n_cnt = 1;
    s_cnt = 0;
    exec(sys);
    exec(1'b0);
    if (sys)
    begin
      s_cnt = 1;
      repeat (2) @(posedge clk);
      acc_done <= ~ab;
      acc_abort <= ab;
      @(posedge clk);
      acc_done <= 1'b0;
      acc_abort <= 1'b0;
      repeat (3) @(posedge clk);
    end
    else
      n_cnt++;
    exec(1'b0);
    n_cnt++;
    #1; // Lets the core's registers settle before the caller reads them.
  endtask

  // Branch out of debug to a given address.
  task automatic leave(input logic [31:0] t);
    @(posedge clk);
    restart <= 1'b1;
    target <= t;
    @(posedge clk);
    restart <= 1'b0;
    target <= ~t;
    #1;
  endtask

  // Return branch counted from the entry base and instructions run.
  task automatic finish(input int base);
    n_cnt++;
    leave(pc + 32'h0000_0004 - 32'((base + n_cnt + 3 * s_cnt) * 4));
  endtask
endmodule
`default_nettype wire

// ==== tb/debug_entry_pc_and_priority_tb.sv ====
// Self-checking bench for the debug entry block.
// Assumes dpe_dbg_model plays the debugger on the far side.
`timescale 1ns/100ps
`default_nettype none
module debug_entry_pc_and_priority_tb;
  import dpe_pkg::*;
  logic clk;
  logic rst_n;
  logic [4:0] ev;
  logic irq, fiq, halt;
  logic [4:0] run_mode;
  logic insn, flag, done, abt, rs;
  logic [31:0] rs_pc, pc, pc0;
  logic [4:0] cur, sav;
  logic dbg, irq_dis, irq_rem, abt_rem, take_pa;
  dpe_cause_t cause;
  int n_errors, num_checks;

  // Device under test.
  dpe_core uut
  (
    .SYS_CLK(clk), .RESET_N(rst_n),
    .BREAKPOINT_HIT(ev[0]), .PREFETCH_ABORT(ev[1]),
    .WATCHPOINT_HIT(ev[2]), .DATA_ABORT(ev[3]),
    .IRQ_PENDING(irq), .FIQ_PENDING(fiq),
    .ABORT_VECTOR_FETCHED(ev[4]), .EXTERNAL_HALT_REQUEST(halt),
    .DEBUG_INSN_EXEC(insn), .SYSTEM_SPEED_FLAG(flag),
    .SYS_ACCESS_DONE(done), .SYS_ACCESS_ABORT(abt),
    .RESTART(rs), .RESTART_PC(rs_pc), .RUN_MODE(run_mode),
    .FETCH_PC(pc), .CURRENT_STATUS_WORD(cur), .SAVED_STATUS_WORD(sav),
    .IN_DEBUG(dbg), .IRQ_DISABLE(irq_dis), .IRQ_REMEMBERED(irq_rem),
    .ABORT_REMEMBERED(abt_rem), .TAKE_PREFETCH_ABORT(take_pa),
    .ENTRY_CAUSE(cause)
  );

  // Debugger model.
  dpe_dbg_model dbg_m
  (
    .clk(clk), .pc(pc), .insn(insn), .flag(flag), .acc_done(done),
    .acc_abort(abt), .restart(rs), .target(rs_pc)
  );

  // Clock at 20 MHz.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task chk_pc(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_f(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle event pulse; returns once the answer has landed.
  task pulse(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 5'h00;
    #1;
  endtask

  task wait_dbg;
    repeat (8)
      if (dbg !== 1'b1)
      begin
        @(posedge clk);
        #1;
      end
  endtask

  task entered(input logic [31:0] words, input logic [4:0] c);
    chk_f(dbg, 1'b1);
    chk_pc(pc, pc0 + (words << 2));
    chk_f(cause, c);
    chk_f(irq_dis, 1'b1);
  endtask

  task back(input int base);
    dbg_m.run(1'b0, 1'b0);
    dbg_m.finish(base);
    chk_pc(pc, pc0);
    chk_f(dbg, 1'b0);
    chk_f(irq_dis, 1'b0);
  endtask

  task s_break;
    irq <= 1'b1;
    pulse(5'h01);
    entered(4, CAUSE_BREAK);
    chk_f(cur, MODE_USER);
    chk_f(irq_rem, 1'b0);
    dbg_m.run(1'b0, 1'b0);
    chk_pc(pc, pc0 + 32'h0000_001C);
    chk_f(cur, MODE_USER);
    irq <= 1'b0;
    dbg_m.finish(4);
    chk_pc(pc, pc0);
  endtask

  task s_prefetch;
    pulse(5'h03);
    chk_f(take_pa, 1'b1);
    chk_f(dbg, 1'b0);
  endtask

  task s_watch;
    pulse(5'h04);
    entered(4, CAUSE_WATCH);
    dbg_m.run(1'b1, 1'b0);
    chk_pc(pc, pc0 + 32'h0000_0024);
    dbg_m.finish(4);
    chk_pc(pc, pc0);
  endtask

  task s_watch_exc(input int k);
    logic [4:0] md;
    md = (k == 0) ? MODE_IRQ : (k == 1) ? MODE_FIQ : MODE_ABORT;
    if (k != 1)
      chk_f((k == 2) ? abt_rem : irq_rem, 1'b0);
    irq <= (k == 0);
    fiq <= (k == 1);
    pulse((k == 2) ? 5'h0C : 5'h04);
    chk_f(dbg, 1'b0);
    pulse(5'h10);
    wait_dbg;
    irq <= 1'b0;
    fiq <= 1'b0;
    entered(3, CAUSE_WATCH_EXC);
    chk_f(cur, md);
    chk_f(sav, MODE_USER);
    chk_f((k == 2) ? abt_rem : irq_rem, 1'b1);
    back(3);
  endtask

  task s_halt;
    halt <= 1'b1;
    @(posedge clk);
    #1;
    wait_dbg;
    halt <= 1'b0;
    entered(3, CAUSE_HALT_REQ);
    back(3);
  endtask

  task s_sys_abort;
    pulse(5'h01);
    dbg_m.run(1'b1, 1'b1);
    chk_f(cause, CAUSE_SYS_ABORT);
    chk_f(cur, MODE_ABORT);
    chk_pc(pc, pc0 + 32'h0000_0024);
    dbg_m.finish(4);
    chk_pc(pc, pc0);
  endtask

  task s_wrap;
    pulse(5'h01);
    dbg_m.run(1'b0, 1'b0);
    dbg_m.leave(32'hFFFF_FFF8);
    pc0 = 32'hFFFF_FFF8;
    pulse(5'h01);
    chk_pc(pc, 32'h0000_0008);
    back(4);
  endtask

  task end_sim;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    ev = 5'h00;
    irq = 1'b0;
    fiq = 1'b0;
    halt = 1'b0;
    run_mode = MODE_USER;
    rst_n = 1'b0;
    n_errors = 0;
    num_checks = 0;
    pc0 = PC_RESET;
    repeat (4) @(posedge clk);
    #1;
    chk_pc(pc, PC_RESET);
    chk_f(cur, MODE_SVC);
    chk_f(sav, MODE_SVC);
    chk_f(cause, CAUSE_NONE);
    @(posedge clk);
    rst_n <= 1'b1;
    s_break;
    s_prefetch;
    s_watch;
    s_halt;
    for (int k = 0; k < 3; k++)
      s_watch_exc(k);
    s_sys_abort;
    s_wrap;
    end_sim;
  end

  // Watchdog against a hang.
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
